// ---- design/dpdc_defines.svh ----
`ifndef DPDC_DEFINES_SVH
`define DPDC_DEFINES_SVH

// Register port widths
`define DPDC_ADDR_W 8
`define DPDC_DATA_W 8

// Register offsets
`define DPDC_ADDR_FB_CASCADE 8'h03
`define DPDC_ADDR_FS_BYPASS 8'h0A
`define DPDC_ADDR_PUMP1 8'h10
`define DPDC_ADDR_OSC_OUT 8'h11
`define DPDC_ADDR_PUMP2 8'h12
`define DPDC_ADDR_SFB_LO 8'h20
`define DPDC_ADDR_SFB_HI 8'h21
`define DPDC_ADDR_PREDIV 8'h22
`define DPDC_ADDR_SEL 8'h23
`define DPDC_ADDR_STATUS 8'h24

// Writable bit masks, reserved positions are zero
`define DPDC_MASK_FB_CASCADE 8'h81
`define DPDC_MASK_FS_BYPASS 8'h01
`define DPDC_MASK_PUMP1 8'hDF
`define DPDC_MASK_OSC_OUT 8'hFF
`define DPDC_MASK_PUMP2 8'h7F
`define DPDC_MASK_SFB_HI 8'h01
`define DPDC_MASK_PREDIV 8'h3F
`define DPDC_MASK_SEL 8'h03

// Reset values
`define DPDC_RST_FB_CASCADE 8'h00
`define DPDC_RST_FS_BYPASS 8'h00
`define DPDC_RST_PUMP1 8'h58
`define DPDC_RST_OSC_OUT 8'h00
`define DPDC_RST_PUMP2 8'h00
`define DPDC_RST_SFB 9'h018
`define DPDC_RST_PREDIV 6'h00
`define DPDC_RST_SEL 8'h00

// Field positions
`define DPDC_BIT_CASCADE 0
`define DPDC_BIT_MV1_MSB 7
`define DPDC_BIT_BYPASS 0
`define DPDC_BIT_DOUBLER 0
`define DPDC_BIT_OSC 1
`define DPDC_BIT_SFB_HI 0

// Status byte bit positions
`define DPDC_STAT_VALID 0
`define DPDC_STAT_BYPASS 1
`define DPDC_STAT_DOUBLER 2
`define DPDC_STAT_ALT_OSC 3
`define DPDC_STAT_PLL_EN 4
`define DPDC_STAT_CASCADE 5

// Limits
`define DPDC_SFB_MIN 9'h008
`define DPDC_PREDIV_OFF 6'h00

`endif

// ---- design/dpdc_pkg.sv ----
package dpdc_pkg;

    typedef enum logic [0:0] {
        DPDC_OSC_LOWER = 1'b0,
        DPDC_OSC_ALT = 1'b1
    } dpdc_osc_t;

    typedef enum logic [0:0] {
        DPDC_FB_PRIMARY = 1'b0,
        DPDC_FB_PRODUCT = 1'b1
    } dpdc_fb_path_t;

endpackage

// ---- design/dpdc_path_decode.sv ----
`include "dpdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module dpdc_path_decode (
    input wire logic doubler_select,
    input wire logic [5:0] second_input_prediv,
    input wire dpdc_pkg::dpdc_osc_t oscillator_range_select,
    input wire dpdc_pkg::dpdc_fb_path_t feedback_cascade_bit,
    input wire logic first_stage_bypass_bit,
    output logic prediv_bypass,
    output logic doubler_en,
    output logic lower_osc_en,
    output logic alternate_osc_en,
    output logic feedback_cascade_en,
    output logic first_stage_pll_en,
    output logic first_stage_route_around
);
    import dpdc_pkg::*;

    // Doubler overrides the pre-divider, zero also bypasses it
    assign doubler_en = doubler_select;
    assign prediv_bypass = doubler_select || (second_input_prediv == `DPDC_PREDIV_OFF);

    assign lower_osc_en = (oscillator_range_select == DPDC_OSC_LOWER);
    assign alternate_osc_en = (oscillator_range_select == DPDC_OSC_ALT);

    assign feedback_cascade_en = (feedback_cascade_bit == DPDC_FB_PRODUCT);

    assign first_stage_route_around = first_stage_bypass_bit;
    assign first_stage_pll_en = !first_stage_bypass_bit;
endmodule

`default_nettype wire

// ---- design/dpdc_config_regs.sv ----
// Operation
// - 9-bit second feedback divide, 8..511, reset 24
// - 6-bit pre-divide; zero default bypasses it
// - Doubler off: feed input through pre-divider
// - Doubler on: doubled input, pre-divider ignored
// - Range bit 0 selects lower oscillator
// - Range bit 1 selects alternate oscillator
// - Cascade bit picks primary or product feedback
// - Bypass bit disables first stage PLL
`include "dpdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module dpdc_config_regs (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [`DPDC_ADDR_W-1:0] reg_addr,
    input wire logic [`DPDC_DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [`DPDC_DATA_W-1:0] reg_rdata,
    output logic [8:0] second_feedback_div,
    output logic second_feedback_valid,
    output logic [5:0] second_input_prediv,
    output logic prediv_bypass,
    output logic doubler_en,
    output logic lower_osc_en,
    output logic alternate_osc_en,
    output logic feedback_cascade_en,
    output logic secondary_feedback_msb,
    output logic first_stage_pll_en,
    output logic first_stage_route_around,
    output logic [`DPDC_DATA_W-1:0] first_stage_pump_cfg,
    output logic [`DPDC_DATA_W-1:0] osc_output_cfg,
    output logic [`DPDC_DATA_W-1:0] second_stage_pump_cfg
);
    import dpdc_pkg::*;

    logic [`DPDC_DATA_W-1:0] feedback_cascade_ctrl_reg;
    logic [`DPDC_DATA_W-1:0] first_stage_bypass_ctrl_reg;
    logic [`DPDC_DATA_W-1:0] first_stage_pump_ctrl_reg;
    logic [`DPDC_DATA_W-1:0] osc_output_offset_ctrl_reg;
    logic [`DPDC_DATA_W-1:0] second_stage_pump_ctrl_reg;
    logic [8:0] second_feedback_div_reg;
    logic [5:0] second_input_prediv_reg;
    logic [`DPDC_DATA_W-1:0] path_select_reg;
    logic [`DPDC_DATA_W-1:0] status_next;
    logic [`DPDC_DATA_W-1:0] rdata_next;
    logic [`DPDC_DATA_W-1:0] reg_rdata_reg;
    dpdc_osc_t osc_sel;
    dpdc_fb_path_t fb_sel;

    // Keep only the implemented bits of a written byte
    function automatic logic [`DPDC_DATA_W-1:0] keep_bits(
        input logic [`DPDC_DATA_W-1:0] data,
        input logic [`DPDC_DATA_W-1:0] mask
    );
        keep_bits = data & mask;
    endfunction

    function automatic logic wr_hit(
        input logic wr,
        input logic [`DPDC_ADDR_W-1:0] addr,
        input logic [`DPDC_ADDR_W-1:0] target
    );
        wr_hit = wr && (addr == target);
    endfunction

    // Cascade select and secondary divider MSB
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            feedback_cascade_ctrl_reg <= `DPDC_RST_FB_CASCADE;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FB_CASCADE)) begin
            feedback_cascade_ctrl_reg <= keep_bits(reg_wdata, `DPDC_MASK_FB_CASCADE);
        end
    end

    // First stage bypass
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_stage_bypass_ctrl_reg <= `DPDC_RST_FS_BYPASS;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FS_BYPASS)) begin
            first_stage_bypass_ctrl_reg <= keep_bits(reg_wdata, `DPDC_MASK_FS_BYPASS);
        end
    end

    // First stage pump byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            first_stage_pump_ctrl_reg <= `DPDC_RST_PUMP1;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PUMP1)) begin
            first_stage_pump_ctrl_reg <= keep_bits(reg_wdata, `DPDC_MASK_PUMP1);
        end
    end

    // Oscillator output byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            osc_output_offset_ctrl_reg <= `DPDC_RST_OSC_OUT;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_OSC_OUT)) begin
            osc_output_offset_ctrl_reg <= keep_bits(reg_wdata, `DPDC_MASK_OSC_OUT);
        end
    end

    // Second stage pump byte
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            second_stage_pump_ctrl_reg <= `DPDC_RST_PUMP2;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PUMP2)) begin
            second_stage_pump_ctrl_reg <= keep_bits(reg_wdata, `DPDC_MASK_PUMP2);
        end
    end

    // Second stage feedback divider, split over two bytes
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            second_feedback_div_reg <= `DPDC_RST_SFB;
        end else begin
            if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_LO)) begin
                second_feedback_div_reg[7:0] <= reg_wdata;
            end
            if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_HI)) begin
                second_feedback_div_reg[8] <= reg_wdata[`DPDC_BIT_SFB_HI];
            end
        end
    end

    // Second stage pre-divider
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            second_input_prediv_reg <= `DPDC_RST_PREDIV;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PREDIV)) begin
            second_input_prediv_reg <= reg_wdata[5:0];
        end
    end

    // Doubler and oscillator range selects
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            path_select_reg <= `DPDC_RST_SEL;
        end else if (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL)) begin
            path_select_reg <= keep_bits(reg_wdata, `DPDC_MASK_SEL);
        end
    end

    assign osc_sel = dpdc_osc_t'(path_select_reg[`DPDC_BIT_OSC]);
    assign fb_sel = dpdc_fb_path_t'(feedback_cascade_ctrl_reg[`DPDC_BIT_CASCADE]);

    dpdc_path_decode u_decode (
        .doubler_select(path_select_reg[`DPDC_BIT_DOUBLER]),
        .second_input_prediv(second_input_prediv_reg),
        .oscillator_range_select(osc_sel),
        .feedback_cascade_bit(fb_sel),
        .first_stage_bypass_bit(first_stage_bypass_ctrl_reg[`DPDC_BIT_BYPASS]),
        .prediv_bypass(prediv_bypass),
        .doubler_en(doubler_en),
        .lower_osc_en(lower_osc_en),
        .alternate_osc_en(alternate_osc_en),
        .feedback_cascade_en(feedback_cascade_en),
        .first_stage_pll_en(first_stage_pll_en),
        .first_stage_route_around(first_stage_route_around)
    );

    assign second_feedback_valid = (second_feedback_div_reg >= `DPDC_SFB_MIN);

    // Read-only view of the decoded paths
    always_comb begin
        status_next = '0;
        status_next[`DPDC_STAT_VALID] = second_feedback_valid;
        status_next[`DPDC_STAT_BYPASS] = prediv_bypass;
        status_next[`DPDC_STAT_DOUBLER] = doubler_en;
        status_next[`DPDC_STAT_ALT_OSC] = alternate_osc_en;
        status_next[`DPDC_STAT_PLL_EN] = first_stage_pll_en;
        status_next[`DPDC_STAT_CASCADE] = feedback_cascade_en;
    end

    // Read decode, unmapped addresses return zero
    always_comb begin
        rdata_next = '0;
        case (reg_addr)
            `DPDC_ADDR_FB_CASCADE: rdata_next = feedback_cascade_ctrl_reg;
            `DPDC_ADDR_FS_BYPASS: rdata_next = first_stage_bypass_ctrl_reg;
            `DPDC_ADDR_PUMP1: rdata_next = first_stage_pump_ctrl_reg;
            `DPDC_ADDR_OSC_OUT: rdata_next = osc_output_offset_ctrl_reg;
            `DPDC_ADDR_PUMP2: rdata_next = second_stage_pump_ctrl_reg;
            `DPDC_ADDR_SFB_LO: rdata_next = second_feedback_div_reg[7:0];
            `DPDC_ADDR_SFB_HI: rdata_next = {7'h00, second_feedback_div_reg[8]};
            `DPDC_ADDR_PREDIV: rdata_next = {2'h0, second_input_prediv_reg};
            `DPDC_ADDR_SEL: rdata_next = path_select_reg;
            `DPDC_ADDR_STATUS: rdata_next = status_next;
            default: rdata_next = '0;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_reg <= '0;
        end else if (reg_rd) begin
            reg_rdata_reg <= rdata_next;
        end else begin
            reg_rdata_reg <= '0;
        end
    end

    assign reg_rdata = reg_rdata_reg;
    assign second_feedback_div = second_feedback_div_reg;
    assign second_input_prediv = second_input_prediv_reg;
    assign secondary_feedback_msb = feedback_cascade_ctrl_reg[`DPDC_BIT_MV1_MSB];
    assign first_stage_pump_cfg = first_stage_pump_ctrl_reg;
    assign osc_output_cfg = osc_output_offset_ctrl_reg;
    assign second_stage_pump_cfg = second_stage_pump_ctrl_reg;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    // Feedback divider checks
    a_sfb_low_write: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_LO)
        |=> second_feedback_div[7:0] == $past(reg_wdata) && second_feedback_div[8] == $past(second_feedback_div[8])
    ) else $error("feedback divider low byte not stored");

    a_sfb_high_write: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_HI)
        |=> second_feedback_div[8] == $past(reg_wdata[`DPDC_BIT_SFB_HI])
        && second_feedback_div[7:0] == $past(second_feedback_div[7:0])
    ) else $error("feedback divider high bit not stored");

    a_sfb_hold: assert property (
        !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_LO) && !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_HI)
        |=> $stable(second_feedback_div)
    ) else $error("feedback divider changed without a write");

    a_sfb_valid_range: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SFB_LO) && reg_wdata < 8'(`DPDC_SFB_MIN) && !second_feedback_div[8]
        |=> !second_feedback_valid
    ) else $error("feedback divider validity wrong");

    a_sfb_read_back: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_SFB_LO |=> reg_rdata == $past(second_feedback_div[7:0])
    ) else $error("feedback divider low byte read wrong");

    a_reset_defaults: assert property (
        $fell(rst) |-> second_feedback_div == `DPDC_RST_SFB && second_input_prediv == `DPDC_RST_PREDIV
        && !doubler_en && lower_osc_en && !feedback_cascade_en && first_stage_pll_en
    ) else $error("reset defaults wrong");

    // Path select checks
    a_prediv_store: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PREDIV) |=> second_input_prediv == $past(reg_wdata[5:0])
    ) else $error("pre-divide value not stored");

    a_prediv_hold: assert property (
        !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PREDIV) |=> $stable(second_input_prediv)
    ) else $error("pre-divide changed without a write");

    a_prediv_zero_bypass: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_PREDIV) && reg_wdata[5:0] == `DPDC_PREDIV_OFF |=> prediv_bypass
    ) else $error("zero pre-divide not bypassed");

    a_prediv_path_used: assert property (
        !path_select_reg[`DPDC_BIT_DOUBLER] && second_input_prediv != `DPDC_PREDIV_OFF |-> !prediv_bypass && !doubler_en
    ) else $error("pre-divider path not used");

    a_doubler_off: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) && !reg_wdata[`DPDC_BIT_DOUBLER]
        |=> !doubler_en && prediv_bypass == (second_input_prediv == `DPDC_PREDIV_OFF)
    ) else $error("doubler not released");

    a_doubler_overrides: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) && reg_wdata[`DPDC_BIT_DOUBLER] |=> doubler_en && prediv_bypass
    ) else $error("doubler did not override pre-divider");

    a_select_hold: assert property (
        !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) |=> $stable(doubler_en) && $stable(alternate_osc_en)
    ) else $error("path select changed without a write");

    a_osc_lower_sel: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) && !reg_wdata[`DPDC_BIT_OSC] |=> lower_osc_en && !alternate_osc_en
    ) else $error("lower oscillator not selected");

    a_osc_alt_sel: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) && reg_wdata[`DPDC_BIT_OSC] |=> alternate_osc_en && !lower_osc_en
    ) else $error("alternate oscillator not selected");

    a_cascade_follows: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FB_CASCADE) |=> feedback_cascade_en == $past(reg_wdata[`DPDC_BIT_CASCADE])
    ) else $error("feedback cascade select wrong");

    a_cascade_hold: assert property (
        !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FB_CASCADE) |=> $stable(feedback_cascade_en) && $stable(secondary_feedback_msb)
    ) else $error("cascade byte changed without a write");

    a_msb_follows: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FB_CASCADE) |=> secondary_feedback_msb == $past(reg_wdata[`DPDC_BIT_MV1_MSB])
    ) else $error("secondary divider msb not stored");

    a_bypass_follows: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FS_BYPASS)
        |=> first_stage_route_around == $past(reg_wdata[`DPDC_BIT_BYPASS]) && first_stage_pll_en == !$past(reg_wdata[`DPDC_BIT_BYPASS])
    ) else $error("first stage bypass wrong");

    a_bypass_hold: assert property (
        !wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FS_BYPASS) |=> $stable(first_stage_pll_en)
    ) else $error("first stage bypass changed without a write");

    // Register bus checks
    a_reserved_read_zero: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_FB_CASCADE |=> (reg_rdata & ~`DPDC_MASK_FB_CASCADE) == 8'h00
    ) else $error("reserved bits read nonzero");

    a_reserved_bypass_zero: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_FS_BYPASS |=> (reg_rdata & ~`DPDC_MASK_FS_BYPASS) == 8'h00
    ) else $error("reserved bypass bits read nonzero");

    a_reserved_pump1_zero: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_PUMP1 |=> (reg_rdata & ~`DPDC_MASK_PUMP1) == 8'h00
    ) else $error("reserved first pump bit read nonzero");

    a_reserved_pump2_zero: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_PUMP2 |=> (reg_rdata & ~`DPDC_MASK_PUMP2) == 8'h00
    ) else $error("reserved second pump bit read nonzero");

    a_osc_out_store: assert property (
        wr_hit(reg_wr, reg_addr, `DPDC_ADDR_OSC_OUT) |=> osc_output_cfg == $past(reg_wdata)
    ) else $error("oscillator output byte not stored");

    a_status_read: assert property (
        reg_rd && reg_addr == `DPDC_ADDR_STATUS
        |=> reg_rdata[`DPDC_STAT_ALT_OSC] == $past(alternate_osc_en) && reg_rdata[`DPDC_STAT_PLL_EN] == $past(first_stage_pll_en)
    ) else $error("status byte read wrong");

    a_read_one_cycle: assert property (
        !reg_rd |=> reg_rdata == 8'h00
    ) else $error("read data outside its cycle");

    c_doubler_on: cover property (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_SEL) && reg_wdata[`DPDC_BIT_DOUBLER]
        ##1 doubler_en);
    c_alt_osc: cover property (lower_osc_en ##[1:20] alternate_osc_en);
    c_bypass_read: cover property (first_stage_route_around ##1 reg_rd && reg_addr == `DPDC_ADDR_STATUS);
    c_sfb_invalid: cover property (!second_feedback_valid);
    c_cascade_product: cover property (wr_hit(reg_wr, reg_addr, `DPDC_ADDR_FB_CASCADE)
        && reg_wdata[`DPDC_BIT_CASCADE] ##1 feedback_cascade_en);
endmodule

`default_nettype wire

// ---- bench/tb_top.sv ----
`include "dpdc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic ref_clk;
    logic rst;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [8:0] second_feedback_div;
    logic second_feedback_valid;
    logic [5:0] second_input_prediv;
    logic prediv_bypass;
    logic doubler_en;
    logic lower_osc_en;
    logic alternate_osc_en;
    logic feedback_cascade_en;
    logic secondary_feedback_msb;
    logic first_stage_pll_en;
    logic first_stage_route_around;
    logic [7:0] first_stage_pump_cfg;
    logic [7:0] osc_output_cfg;
    logic [7:0] second_stage_pump_cfg;
    int failures;
    int checks_done;

    dpdc_config_regs u_dut (
        .ref_clk(ref_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .second_feedback_div(second_feedback_div),
        .second_feedback_valid(second_feedback_valid),
        .second_input_prediv(second_input_prediv),
        .prediv_bypass(prediv_bypass),
        .doubler_en(doubler_en),
        .lower_osc_en(lower_osc_en),
        .alternate_osc_en(alternate_osc_en),
        .feedback_cascade_en(feedback_cascade_en),
        .secondary_feedback_msb(secondary_feedback_msb),
        .first_stage_pll_en(first_stage_pll_en),
        .first_stage_route_around(first_stage_route_around),
        .first_stage_pump_cfg(first_stage_pump_cfg),
        .osc_output_cfg(osc_output_cfg),
        .second_stage_pump_cfg(second_stage_pump_cfg)
    );

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= addr;
        reg_wdata <= data;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= addr;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk("read data", {8'h00, reg_rdata}, {8'h00, exp});
        @(posedge ref_clk);
        #1;
        chk("read data idle", {8'h00, reg_rdata}, 16'h0000);
    endtask

    // Order: bypass, doubler, lower, alternate, cascade, pll_en, route_around
    task automatic chk_dec(input logic [6:0] exp);
        chk("decoded selects", {9'h000, prediv_bypass, doubler_en, lower_osc_en, alternate_osc_en,
            feedback_cascade_en, first_stage_pll_en, first_stage_route_around}, {9'h000, exp});
    endtask

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #(40 * 3000);
        failures++;
        wrap_up();
    end

    initial begin
        failures = 0;
        checks_done = 0;
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset state
        chk("feedback div", {7'h00, second_feedback_div}, 16'h0018);
        chk("prediv", {10'h000, second_input_prediv}, 16'h0000);
        chk_dec(7'b1010010);
        chk("secondary msb rst", {15'h0000, secondary_feedback_msb}, 16'h0000);
        chk("pump1", {8'h00, first_stage_pump_cfg}, 16'h0058);
        chk("osc out", {8'h00, osc_output_cfg}, 16'h0000);
        chk("pump2", {8'h00, second_stage_pump_cfg}, 16'h0000);
        rd_chk(`DPDC_ADDR_SFB_LO, 8'h18);
        rd_chk(`DPDC_ADDR_SFB_HI, 8'h00);
        rd_chk(`DPDC_ADDR_STATUS, 8'h13);
        // Feedback divide bounds
        wr(`DPDC_ADDR_SFB_LO, 8'hFF);
        wr(`DPDC_ADDR_SFB_HI, 8'hFF);
        chk("feedback div max", {7'h00, second_feedback_div}, 16'h01FF);
        chk("feedback valid", {15'h0000, second_feedback_valid}, 16'h0001);
        rd_chk(`DPDC_ADDR_SFB_HI, 8'h01);
        wr(`DPDC_ADDR_SFB_HI, 8'h00);
        wr(`DPDC_ADDR_SFB_LO, 8'h08);
        chk("feedback valid min", {15'h0000, second_feedback_valid}, 16'h0001);
        wr(`DPDC_ADDR_SFB_LO, 8'h07);
        chk("feedback div low", {7'h00, second_feedback_div}, 16'h0007);
        chk("feedback invalid", {15'h0000, second_feedback_valid}, 16'h0000);
        // Pre-divide and doubler, divider left invalid until the mid-run reset
        wr(`DPDC_ADDR_PREDIV, 8'hFF);
        chk("prediv max", {10'h000, second_input_prediv}, 16'h003F);
        chk_dec(7'b0010010);
        rd_chk(`DPDC_ADDR_PREDIV, 8'h3F);
        wr(`DPDC_ADDR_PREDIV, 8'h01);
        chk_dec(7'b0010010);
        wr(`DPDC_ADDR_SEL, 8'h01);
        chk_dec(7'b1110010);
        rd_chk(`DPDC_ADDR_STATUS, 8'h16);
        wr(`DPDC_ADDR_SEL, 8'h00);
        chk_dec(7'b0010010);
        wr(`DPDC_ADDR_PREDIV, 8'h00);
        chk_dec(7'b1010010);
        // Oscillator range
        wr(`DPDC_ADDR_SEL, 8'hFE);
        chk_dec(7'b1001010);
        rd_chk(`DPDC_ADDR_SEL, 8'h02);
        rd_chk(`DPDC_ADDR_STATUS, 8'h1A);
        wr(`DPDC_ADDR_SEL, 8'h00);
        chk_dec(7'b1010010);
        // First stage feedback cascade
        wr(`DPDC_ADDR_FB_CASCADE, 8'hFF);
        chk_dec(7'b1010110);
        chk("secondary msb", {15'h0000, secondary_feedback_msb}, 16'h0001);
        rd_chk(`DPDC_ADDR_FB_CASCADE, 8'h81);
        wr(`DPDC_ADDR_FB_CASCADE, 8'h7E);
        chk_dec(7'b1010010);
        chk("secondary msb clear", {15'h0000, secondary_feedback_msb}, 16'h0000);
        rd_chk(`DPDC_ADDR_FB_CASCADE, 8'h00);
        // First stage bypass
        wr(`DPDC_ADDR_FS_BYPASS, 8'hFF);
        chk_dec(7'b1010001);
        rd_chk(`DPDC_ADDR_FS_BYPASS, 8'h01);
        rd_chk(`DPDC_ADDR_STATUS, 8'h02);
        wr(`DPDC_ADDR_FS_BYPASS, 8'h00);
        chk_dec(7'b1010010);
        // Reserved bits and unmapped places
        wr(`DPDC_ADDR_PUMP1, 8'hFF);
        chk("pump1 mask", {8'h00, first_stage_pump_cfg}, 16'h00DF);
        rd_chk(`DPDC_ADDR_PUMP1, 8'hDF);
        wr(`DPDC_ADDR_PUMP2, 8'hFF);
        chk("pump2 mask", {8'h00, second_stage_pump_cfg}, 16'h007F);
        rd_chk(`DPDC_ADDR_PUMP2, 8'h7F);
        wr(`DPDC_ADDR_OSC_OUT, 8'hA5);
        chk("osc out byte", {8'h00, osc_output_cfg}, 16'h00A5);
        rd_chk(`DPDC_ADDR_OSC_OUT, 8'hA5);
        wr(8'h40, 8'hFF);
        rd_chk(8'h40, 8'h00);
        wr(`DPDC_ADDR_STATUS, 8'hFF);
        rd_chk(`DPDC_ADDR_STATUS, 8'h12);
        // Reset in mid-run restores defaults
        @(posedge ref_clk);
        rst <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        #1;
        chk("feedback div rst", {7'h00, second_feedback_div}, 16'h0018);
        chk("pump1 rst", {8'h00, first_stage_pump_cfg}, 16'h0058);
        chk_dec(7'b1010010);
        rd_chk(`DPDC_ADDR_SFB_LO, 8'h18);
        rd_chk(`DPDC_ADDR_STATUS, 8'h13);
        wrap_up();
    end
endmodule

`default_nettype wire
